// ==== test/pl_link_master_tb_top.sv ====
// bench for the point link master with a slave model on its pins
// assumes the slave model and the bound checker are compiled
`timescale 1ns/1ps
`include "pl_defs.svh"

module pl_link_master_tb_top;
  typedef struct packed {
    logic [1:0] k;
    logic [7:0] d;
    logic       e;
    logic       a;
    logic [7:0] r;
  } pl_row_t;
  localparam logic [7:0] TXB = 8'hC3;
  localparam int DEP = 16;
  logic clock = 1'b0, reset = 1'b1, smbus_mode = 1'b0, cmd_valid = 1'b0;
  logic hold_n = 1'b1, alert = 1'b0, smb_pull;
  logic [1:0] cmd_kind = 2'h0;
  logic [7:0] cmd_data = 8'h00, rsp_data, rx;
  logic cmd_ready, rsp_valid, rsp_ack, rsp_err, slave_alert, link_busy;
  logic link_serial_clock, link_data_out, link_data_out_oe_n;
  logic link_data_in, slave_alert_stretch;
  int err_count = 0, cmp_count = 0, acc, i;
  // pull-up on the shared wire in smbus mode, the slave may pull it low
  wire logic sda_w = (link_data_out_oe_n ? 1'b1 : link_data_out) & !smb_pull;
  pl_row_t rows [9] = '{
    {`PL_KIND_WRITE, 8'h5A, 1'b1, 1'b0, `PL_NO_DATA},
    {`PL_KIND_START, 8'h00, 1'b0, 1'b0, `PL_NO_DATA},
    {`PL_KIND_WRITE, 8'hA5, 1'b0, 1'b1, `PL_NO_DATA},
    {`PL_KIND_READ, 8'h00, 1'b0, 1'b1, TXB},
    {`PL_KIND_START, 8'h00, 1'b0, 1'b0, `PL_NO_DATA},
    {`PL_KIND_WRITE, 8'h3C, 1'b0, 1'b1, `PL_NO_DATA},
    {`PL_KIND_READ, 8'h01, 1'b0, 1'b0, TXB},
    {`PL_KIND_STOP, 8'h00, 1'b0, 1'b0, `PL_NO_DATA},
    {`PL_KIND_STOP, 8'h00, 1'b0, 1'b0, `PL_NO_DATA}};

  pl_link_master #(.HALF_CYC(3), .DEPTH(DEP)) DUT (
    .clock, .reset, .smbus_mode, .cmd_valid, .cmd_kind, .cmd_data,
    .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack, .rsp_err, .slave_alert,
    .link_busy, .link_serial_clock, .link_data_out, .link_data_out_oe_n,
    .link_data_out_in(sda_w), .link_data_in, .slave_alert_stretch);
  pl_slave_model #(.TXB(TXB)) u_slave (
    .sck(link_serial_clock), .sdo(sda_w), .hold_n, .alert,
    .smb(smbus_mode), .pull(smb_pull),
    .sdi(link_data_in), .sas(slave_alert_stretch), .rx);

  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [1:0] k, input logic [7:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_data <= d;
    do @(negedge clock); while (cmd_ready !== 1'b1);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  // hangs here are cut by the cycle ceiling below
  task automatic wait_rsp;
    do @(negedge clock); while (rsp_valid !== 1'b1);
  endtask
  task automatic wait_idle;
    do @(negedge clock); while (link_busy !== 1'b0);
    @(posedge clock);
  endtask
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial forever #10 clock = !clock;
  initial
  begin
    repeat (40000) @(posedge clock);
    err_count++;
    conclude();
  end

  // ********
  // sequence
  // ********
  initial
  begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("idle pins", 8'h1A, {3'h0, link_serial_clock, link_data_out,
        link_data_out_oe_n, cmd_ready, link_busy});
    for (i = 0; i < 9; i++)
    begin
      send(rows[i].k, rows[i].d);
      if (rows[i].k == `PL_KIND_WRITE || rows[i].k == `PL_KIND_READ)
      begin
        wait_rsp();
        chk("err", {7'h0, rows[i].e}, {7'h0, rsp_err});
        chk("data", rows[i].r, rsp_data);
        if (!rows[i].e)
          chk("ack", {7'h0, rows[i].a}, {7'h0, rsp_ack});
        if (!rows[i].e && rows[i].k == `PL_KIND_WRITE)
          chk("rx", rows[i].d, rx);
      end
    end
    wait_idle();
    send(`PL_KIND_START, 8'h00);
    send(`PL_KIND_WRITE, 8'h96);
    repeat (20) @(posedge clock);
    hold_n <= 1'b0;
    repeat (40) @(posedge clock);
    hold_n <= 1'b1;
    wait_rsp();
    chk("stretch ack", 8'h01, {7'h0, rsp_ack});
    chk("stretch rx", 8'h96, rx);
    @(posedge clock);
    hold_n <= 1'b0;
    repeat (6) @(posedge clock);
    cmd_kind <= `PL_KIND_WRITE;
    cmd_data <= 8'h81;
    cmd_valid <= 1'b1;
    acc = 0;
    repeat (24)
    begin
      @(negedge clock);
      if (cmd_ready === 1'b1)
        acc++;
    end
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    chk("fill", 8'h01, {7'h0, acc == DEP});
    chk("full", 8'h00, {7'h0, cmd_ready});
    @(posedge clock);
    hold_n <= 1'b1;
    repeat (acc)
    begin
      wait_rsp();
      chk("drain ack", 8'h01, {7'h0, rsp_ack});
    end
    send(`PL_KIND_STOP, 8'h00);
    wait_idle();
    alert <= 1'b1;
    repeat (8) @(negedge clock);
    chk("alert", 8'h01, {7'h0, slave_alert});
    @(posedge clock);
    alert <= 1'b0;
    repeat (4) @(negedge clock);
    chk("alert held", 8'h01, {7'h0, slave_alert});
    send(`PL_KIND_START, 8'h00);
    repeat (30) @(negedge clock);
    chk("alert gone", 8'h00, {7'h0, slave_alert});
    send(`PL_KIND_STOP, 8'h00);
    wait_idle();
    smbus_mode <= 1'b1;
    repeat (4) @(posedge clock);
    send(`PL_KIND_START, 8'h00);
    send(`PL_KIND_WRITE, 8'h81);
    wait_rsp();
    chk("smb ack", 8'h01, {7'h0, rsp_ack});
    chk("smb rx", 8'h81, rx);
    send(`PL_KIND_STOP, 8'h00);
    wait_idle();
    smbus_mode <= 1'b0;
    send(`PL_KIND_START, 8'h00);
    send(`PL_KIND_WRITE, 8'hF0);
    repeat (10) @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("rst busy", 8'h00, {7'h0, link_busy});
    chk("rst clock", 8'h01, {7'h0, link_serial_clock});
    conclude();
  end
endmodule

// ==== test/pl_link_props.sv ====
// pin checker for the point link master
// assumes it is bound onto pl_link_master
`timescale 1ns/1ps

module pl_link_props #(
  parameter int HALF_CYC = 3
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic smbus_mode,
  input wire logic link_busy,
  input wire logic slave_alert,
  input wire logic link_serial_clock,
  input wire logic link_data_out,
  input wire logic link_data_out_oe_n,
  input wire logic slave_alert_stretch
);
  // ********
  // level length of the serial clock
  // ********
  logic       clk_q;
  logic       dat_q;
  logic       bad_q;
  logic [7:0] run_q;
  logic [3:0] sas_q;
  wire        edge_w = link_serial_clock != clk_q;
  // a start or repeated start opens a fresh high run of one half period
  wire        line_w = link_data_out | link_data_out_oe_n;
  wire        fall_w = !line_w && dat_q && link_serial_clock && clk_q;
  // stretch acts through a sync chain, so recent lows spoil the count
  wire        stall_w = !link_busy || !(&sas_q);
  always_ff @(posedge clock)
  begin
    clk_q <= link_serial_clock;
    dat_q <= line_w;
    sas_q <= reset ? 4'h0 : {sas_q[2:0], slave_alert_stretch};
    run_q <= (edge_w || fall_w) ? 8'h01 : run_q + 8'h01;
    bad_q <= reset || stall_w || (!edge_w && !fall_w && bad_q);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence s_stall;
    (link_busy && !slave_alert_stretch)[*5];
  endsequence
  sequence s_quiet;
    (!link_busy && !slave_alert_stretch)[*5];
  endsequence

  AST_HALF_RATE:
    assert property (edge_w && !link_serial_clock && !bad_q
                     |-> run_q == HALF_CYC)
    else $error("clock high half has wrong length");
  AST_STRETCH:
    assert property (s_stall |-> $stable(link_serial_clock))
    else $error("clock moved during stretch");
  AST_START:
    assert property ($rose(link_busy) && !smbus_mode
                     |-> ##[0:1] (!link_data_out && link_serial_clock))
    else $error("frame opened without start");
  AST_IDLE_CLOCK:
    assert property (!link_busy && !$past(link_busy) |-> link_serial_clock)
    else $error("clock not high while idle");
  AST_IDLE_DATA:
    assert property (!link_busy && !$past(link_busy) && !smbus_mode
                     && !$past(smbus_mode) |-> link_data_out)
    else $error("data out not high while idle");
  AST_PUSH_PULL:
    assert property (!smbus_mode && !$past(smbus_mode)
                     && !$past(smbus_mode, 2) |-> !link_data_out_oe_n)
    else $error("data out released in normal mode");
  AST_SMB_DATA:
    assert property (smbus_mode && link_busy |-> !link_data_out)
    else $error("data out driven high in smbus mode");
  AST_ALERT_QUIET:
    assert property (link_busy && $past(link_busy) |-> !slave_alert)
    else $error("alert reported inside a frame");
  AST_ALERT_SEEN:
    assert property (s_quiet |-> slave_alert)
    else $error("idle alert not reported");
endmodule

bind pl_link_master pl_link_props #(
  .HALF_CYC(HALF_CYC)
) u_props (
  .clock, .reset, .smbus_mode, .link_busy, .slave_alert,
  .link_serial_clock, .link_data_out, .link_data_out_oe_n,
  .slave_alert_stretch
);

// ==== test/pl_slave_model.sv ====
// behavioural slave at the far end of the point link
// assumes the master is the only source of the link clock
`timescale 1ns/1ps

module pl_slave_model #(
  parameter logic [7:0] TXB = 8'hC3
) (
  input  wire logic sck,
  input  wire logic sdo,
  input  wire logic hold_n,
  input  wire logic alert,
  input  wire logic smb,
  output logic      pull,
  output logic      sdi,
  output logic      sas,
  output logic [7:0] rx
);
  logic       fr = 1'b0;
  logic       al = 1'b0;
  logic [7:0] sh = 8'h00;
  int         n = 0;
  initial sdi = 1'b1;
  initial pull = 1'b0;
  initial rx = 8'h00;
  // only the data-in, alert and smbus pull lines are ours, never the clock
  assign sas = hold_n && !al;
  always @(posedge alert) al = 1'b1;
  always @(negedge sdo)
    if (sck)
    begin
      fr = 1'b1;
      n = 0;
      al = 1'b0;
    end
  always @(posedge sdo)
    if (sck)
    begin
      fr = 1'b0;
      sdi = !sdi; // a stop inverts the last data-in bit
    end
  always @(posedge sck)
    if (fr)
    begin
      if (n == 8)
      begin
        rx = sh;
        n = 0;
      end
      else
      begin
        sh = {sh[6:0], sdo};
        n = n + 1;
      end
    end
  // smbus ack pulls the shared line from one falling clock to the next
  always @(negedge sck)
    if (fr)
    begin
      sdi = (n < 8) ? TXB[7 - n] : 1'b0;
      pull = smb && n == 8;
    end
endmodule

// ==== verilog/pl_defs.svh ====
// constants for the point link master: rates, command codes, counts
// assumes inclusion by bare name from every file that needs them
`ifndef PL_DEFS_SVH
`define PL_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define PL_SYS_HZ        50000000
`define PL_LINK_HZ       8000000
`define PL_HALF_CYC      (`PL_SYS_HZ / (2 * `PL_LINK_HZ))

// ****************************************
// command kinds
// ****************************************
`define PL_KIND_START    2'h0
`define PL_KIND_WRITE    2'h1
`define PL_KIND_READ     2'h2
`define PL_KIND_STOP     2'h3

// ****************************************
// byte framing and buffering
// ****************************************
`define PL_ACK_IDX       4'h8
`define PL_FIFO_DEPTH    16
`define PL_NO_DATA       8'h00

`endif

// ==== verilog/pl_fifo.sv ====
// synchronous command fifo, first word fall through
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`include "pl_defs.svh"

module pl_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = `PL_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  pl_stream_if.snk wr,
  pl_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("pl_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;

  wire full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push  = wr.valid && !full;
  wire pop   = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= push ? wp_q + 1'b1 : wp_q;
      rp_q <= pop ? rp_q + 1'b1 : rp_q;
    end
  end
endmodule

// ==== verilog/pl_link_master.sv ====
// point link master: turns buffered commands into framed link traffic
// assumes a 50 MHz clock, synchronous reset, link pins from outside
//
// Notes on behaviour
// [RQ1] The link joins exactly one master and one slave and roles never swap.
// [RQ2] The master makes the serial clock at a nominal 8 MHz.
// [RQ3] Data runs on two one-way lines, data out from master, data in back.
// [RQ4] Only the master drives the serial clock, and it always drives it.
// [RQ5] Only the slave drives the alert/stretch line, to ask for a read.
// [RQ6] A slave alert stays asserted until the master's next start.
// [RQ7] While stretch is low in a transfer, the clock holds its level.
// [RQ8] The shared line is an alert when idle and a stretch inside a frame.
// [RQ9] Transfers are framed with start, stop and repeated start as on SMBus.
// [RQ10] In SMBus mode data out is the two-way data line, clock is SCL.
// [RQ11] In normal mode every wire has one push-pull driver, no open drain.
// [RQ12] Bytes go msb first, then one ack bit from the receiver.
`timescale 1ns/1ps
`include "pl_defs.svh"

module pl_link_master #(
  parameter int HALF_CYC = `PL_HALF_CYC,
  parameter int DEPTH    = `PL_FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       smbus_mode,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_kind,
  input  wire logic [7:0] cmd_data,
  output wire logic       cmd_ready,
  output wire logic       rsp_valid,
  output wire logic [7:0] rsp_data,
  output wire logic       rsp_ack,
  output wire logic       rsp_err,
  output wire logic       slave_alert,
  output wire logic       link_busy,
  output wire logic       link_serial_clock,
  output wire logic       link_data_out,
  output wire logic       link_data_out_oe_n,
  input  wire logic       link_data_out_in,
  input  wire logic       link_data_in,
  input  wire logic       slave_alert_stretch
);
  localparam int CW = $bits(pl_pkg::pl_cmd_t);
  localparam int TW = $clog2(HALF_CYC + 1);

  generate
    if (HALF_CYC < 1)
    begin : g_bad_half
      $error("pl_link_master half period must be at least one cycle");
    end
  endgenerate

  // ****************************************
  // helpers
  // ****************************************
  // bit put on data out; a one also releases the line in smbus mode
  function automatic logic bit_out(
    input pl_pkg::pl_kind_t kind,
    input logic [3:0]       idx,
    input logic             dbit,
    input logic             nack
  );
    logic wr;
    wr = (kind == `PL_KIND_WRITE);
    if (idx == `PL_ACK_IDX)
      bit_out = wr ? 1'b1 : nack;                         // [RQ12]
    else
      bit_out = wr ? dbit : 1'b1;                         // [RQ12]
  endfunction

  function automatic logic [TW-1:0] half_load();
    half_load = TW'(HALF_CYC - 1);                        // [RQ2]
  endfunction

  // ****************************************
  // command buffer
  // ****************************************
  pl_stream_if #(.WIDTH(CW)) in_if ();
  pl_stream_if #(.WIDTH(CW)) out_if ();

  logic             pop;
  pl_pkg::pl_cmd_t  f_cmd;

  assign in_if.valid  = cmd_valid;
  assign in_if.data   = {cmd_kind, cmd_data};
  assign cmd_ready    = in_if.ready;
  assign out_if.ready = pop;
  assign f_cmd        = pl_pkg::pl_cmd_t'(out_if.data);

  pl_fifo #(
    .WIDTH (CW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock (clock),
    .reset (reset),
    .wr    (in_if),
    .rd    (out_if)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  // order: alert/stretch, data in, data out read back
  logic [2:0] s1_q;
  logic [2:0] s2_q;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
    end
    else
    begin
      s1_q <= {slave_alert_stretch, link_data_in, link_data_out_in};
      s2_q <= s1_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  pl_pkg::pl_state_t state_q, state_d;
  logic [TW-1:0]     tmr_q, tmr_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        shift_q, shift_d;
  pl_pkg::pl_kind_t  kind_q, kind_d;
  logic              nack_q, nack_d;
  logic              scl_q, scl_d;
  logic              sda_q, sda_d;
  logic              mode_q;
  logic              dout_q;
  logic              oe_n_q;
  logic              alert_q;
  logic              rsp_valid_q, rsp_valid_d;
  logic [7:0]        rsp_data_q, rsp_data_d;
  logic              rsp_ack_q, rsp_ack_d;
  logic              rsp_err_q, rsp_err_d;

  wire stretch_s = s2_q[2];
  wire in_xfer  = (state_q != pl_pkg::PL_IDLE);
  wire halt     = in_xfer && !stretch_s;                  // [RQ7] [RQ8]
  wire done     = (tmr_q == '0) && !halt;                 // [RQ7]
  wire rd_line  = mode_q ? s2_q[0] : s2_q[1];             // [RQ3] [RQ10]
  wire f_valid  = out_if.valid;
  wire f_write  = (f_cmd.kind == `PL_KIND_WRITE);
  wire k_read   = (kind_q == `PL_KIND_READ);
  wire [7:0] shift_in = {shift_q[6:0], rd_line};          // [RQ12]
  wire [3:0] cnt_inc  = cnt_q + 4'h1;

  always_comb
  begin
    state_d     = state_q;
    tmr_d       = (tmr_q != '0 && !halt) ? TW'(tmr_q - 1'b1) : tmr_q;
    cnt_d       = cnt_q;
    shift_d     = shift_q;
    kind_d      = kind_q;
    nack_d      = nack_q;
    scl_d       = scl_q;
    sda_d       = sda_q;
    rsp_valid_d = 1'b0;
    rsp_data_d  = rsp_data_q;
    rsp_ack_d   = rsp_ack_q;
    rsp_err_d   = rsp_err_q;
    pop         = 1'b0;
    case (state_q)
      pl_pkg::PL_IDLE:
      begin
        scl_d = 1'b1;                                     // [RQ4]
        sda_d = 1'b1;
        if (f_valid)
        begin
          pop = 1'b1;
          if (f_cmd.kind == `PL_KIND_START)
          begin
            sda_d   = 1'b0;                               // [RQ9]
            tmr_d   = half_load();
            state_d = pl_pkg::PL_START;
          end
          else if (f_cmd.kind != `PL_KIND_STOP)
          begin
            // a byte outside a frame cannot be sent
            rsp_valid_d = 1'b1;
            rsp_err_d   = 1'b1;
            rsp_ack_d   = 1'b0;
            rsp_data_d  = `PL_NO_DATA;
          end
        end
      end
      pl_pkg::PL_HOLD:
      begin
        if (f_valid && !halt)
        begin
          pop   = 1'b1;
          tmr_d = half_load();
          case (f_cmd.kind)
            `PL_KIND_START:
            begin
              sda_d   = 1'b1;                             // [RQ9]
              state_d = pl_pkg::PL_RS_LOW;
            end
            `PL_KIND_STOP:
            begin
              sda_d   = 1'b0;                             // [RQ9]
              state_d = pl_pkg::PL_STOP_LOW;
            end
            default:
            begin
              kind_d  = f_cmd.kind;
              nack_d  = f_cmd.data[0];
              shift_d = f_write ? f_cmd.data : `PL_NO_DATA;
              cnt_d   = 4'h0;
              sda_d   = bit_out(f_cmd.kind, 4'h0, f_cmd.data[7],
                                f_cmd.data[0]);           // [RQ12]
              state_d = pl_pkg::PL_BIT_LOW;
            end
          endcase
        end
      end
      pl_pkg::PL_START:
      begin
        if (done)
        begin
          scl_d   = 1'b0;
          state_d = pl_pkg::PL_HOLD;
        end
      end
      pl_pkg::PL_BIT_LOW:
      begin
        if (done)
        begin
          scl_d   = 1'b1;                                 // [RQ2]
          tmr_d   = half_load();
          state_d = pl_pkg::PL_BIT_HIGH;
        end
      end
      pl_pkg::PL_BIT_HIGH:
      begin
        if (done)
        begin
          scl_d = 1'b0;
          tmr_d = half_load();
          if (cnt_q == `PL_ACK_IDX)
          begin
            // read data is complete here, the ack bit adds nothing
            rsp_valid_d = 1'b1;
            rsp_err_d   = 1'b0;
            rsp_data_d  = k_read ? shift_q : `PL_NO_DATA;
            rsp_ack_d   = k_read ? !nack_q : !rd_line;    // [RQ12]
            state_d     = pl_pkg::PL_HOLD;
          end
          else
          begin
            shift_d = shift_in;
            cnt_d   = cnt_inc;
            sda_d   = bit_out(kind_q, cnt_inc, shift_q[6], nack_q);
            state_d = pl_pkg::PL_BIT_LOW;
          end
        end
      end
      pl_pkg::PL_RS_LOW:
      begin
        if (done)
        begin
          scl_d   = 1'b1;
          tmr_d   = half_load();
          state_d = pl_pkg::PL_RS_HIGH;
        end
      end
      pl_pkg::PL_RS_HIGH:
      begin
        if (done)
        begin
          sda_d   = 1'b0;                                 // [RQ9]
          tmr_d   = half_load();
          state_d = pl_pkg::PL_START;
        end
      end
      pl_pkg::PL_STOP_LOW:
      begin
        if (done)
        begin
          scl_d   = 1'b1;
          tmr_d   = half_load();
          state_d = pl_pkg::PL_STOP_HIGH;
        end
      end
      pl_pkg::PL_STOP_HIGH:
      begin
        if (done)
        begin
          sda_d   = 1'b1;                                 // [RQ9]
          state_d = pl_pkg::PL_IDLE;
        end
      end
      default:
      begin
        state_d = pl_pkg::PL_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= pl_pkg::PL_IDLE;
      tmr_q   <= '0;
      cnt_q   <= 4'h0;
      shift_q <= `PL_NO_DATA;
      kind_q  <= `PL_KIND_START;
      nack_q  <= 1'b0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      kind_q  <= kind_d;
      nack_q  <= nack_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
    end
  end

  // mode is taken only while idle so a frame never changes signalling
  wire mode_d = in_xfer ? mode_q : smbus_mode;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      mode_q <= 1'b0;
      dout_q <= 1'b1;
      oe_n_q <= 1'b0;
      alert_q <= 1'b0;
    end
    else
    begin
      mode_q  <= mode_d;
      dout_q  <= sda_d & ~mode_d;                         // [RQ10] [RQ11]
      oe_n_q  <= sda_d & mode_d;                          // [RQ10] [RQ11]
      alert_q <= !in_xfer && !stretch_s;                  // [RQ5] [RQ8]
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= `PL_NO_DATA;
      rsp_ack_q   <= 1'b0;
      rsp_err_q   <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
      rsp_ack_q   <= rsp_ack_d;
      rsp_err_q   <= rsp_err_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // single fixed master: the clock pin is never released
  assign link_serial_clock  = scl_q;                      // [RQ1] [RQ4]
  assign link_data_out      = dout_q;                     // [RQ3]
  assign link_data_out_oe_n = oe_n_q;
  assign slave_alert        = alert_q;                    // [RQ6]
  assign link_busy          = in_xfer;
  assign rsp_valid          = rsp_valid_q;
  assign rsp_data           = rsp_data_q;
  assign rsp_ack            = rsp_ack_q;
  assign rsp_err            = rsp_err_q;
endmodule

// ==== verilog/pl_pkg.sv ====
// types shared by the point link master and its command buffer
// assumes nothing of its surroundings
package pl_pkg;

  typedef enum {
    PL_IDLE,
    PL_START,
    PL_HOLD,
    PL_BIT_LOW,
    PL_BIT_HIGH,
    PL_RS_LOW,
    PL_RS_HIGH,
    PL_STOP_LOW,
    PL_STOP_HIGH
  } pl_state_t;

  typedef logic [1:0] pl_kind_t;

  typedef struct packed {
    pl_kind_t   kind;
    logic [7:0] data;
  } pl_cmd_t;

endpackage

// ==== verilog/pl_stream_if.sv ====
// valid/ready word stream between the link master and its buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface pl_stream_if #(
  parameter int WIDTH = 8
) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input  ready
  );

  modport snk (
    input  valid,
    input  data,
    output ready
  );
endinterface
